// ==== verilog/umsbr_regs.vh ====
/*
  Register indexes, field positions and reset values of the block.
  Assumes one 32-bit word per register, data in the low byte.
*/
`ifndef UMSBR_REGS_VH
`define UMSBR_REGS_VH

// ****************************************************************
// Register word indexes (byte address bits 5:2)
// ****************************************************************
`define UMSBR_IDX_RXBUF 4'h0
`define UMSBR_IDX_INTEN 4'h1
`define UMSBR_IDX_FIFOCTL 4'h2
`define UMSBR_IDX_LINECTL 4'h3
`define UMSBR_IDX_MODEMCTL 4'h4
`define UMSBR_IDX_LINESTAT 4'h5
`define UMSBR_IDX_MODEMSTAT 4'h6
`define UMSBR_IDX_SCRATCH 4'h7
`define UMSBR_IDX_DIVLO 4'h8
`define UMSBR_IDX_DIVHI 4'h9

// ****************************************************************
// Field positions
// ****************************************************************
`define UMSBR_INTEN_RXDATA 0
`define UMSBR_INTEN_MODEM 3
`define UMSBR_FIFOCTL_EN 0
`define UMSBR_FIFOCTL_CLR 1
`define UMSBR_MODEMCTL_DTR 0
`define UMSBR_MODEMCTL_RTS 1
`define UMSBR_MODEMCTL_USER1 2
`define UMSBR_MODEMCTL_USER2 3
`define UMSBR_MODEMCTL_LOOP 4
`define UMSBR_MODEMCTL_AUTOFLOW 5
`define UMSBR_LINECTL_STOP 2
`define UMSBR_LINECTL_PAREN 3
`define UMSBR_LINECTL_EVEN 4
`define UMSBR_LINECTL_STICK 5

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define UMSBR_RST_BYTE 8'h00
`define UMSBR_RST_DIV 16'h0000
`define UMSBR_RST_LINECTL 8'h03
`define UMSBR_BUS_ZERO 32'h0000_0000
`define UMSBR_MID_START 4'h7
`define UMSBR_MID_BIT 4'hF

`endif

// ==== verilog/umsbr_rx_fifo.v ====
/*
  Receive buffer array: one write port, one registered read port.
  Assumes the caller keeps pointers and count.
*/
`timescale 1ns/1ns

module umsbr_rx_fifo #(
  parameter WIDTH = 11,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire i_clk,
  input wire i_wr_en,
  input wire [AW-1:0] i_wr_addr,
  input wire [WIDTH-1:0] i_wr_data,
  input wire [AW-1:0] i_rd_addr,
  output reg [WIDTH-1:0] o_rd_data
);

  // ****************************************************************
  // Array
  // ****************************************************************
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Character plus error flags

  // Write port; no reset so the array maps onto plain RAM
  always @(posedge i_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  // Registered read; caller allows one clock after a pointer move
  always @(posedge i_clk) begin
    o_rd_data <= mem[i_rd_addr];
  end

endmodule // umsbr_rx_fifo

// ==== verilog/umsbr_top.v ====
/*
  Modem status, baud generator, receive path and scratch register,
  reached over Avalon-MM with waitrequest.
  Assumes i_clk is also the baud reference clock.
*/
// Chosen here: register access over Avalon-MM and the register offsets.
// Overview of operation
// [R1] Reading modem status clears four change bits
// [R2] Bit 0 flags any CTS level change; code holds bit 0 at zero while autoflow is enabled
// [R3] CTS change interrupts only without autoflow
// [R4] Bit 1 flags any DSR level change
// [R5] Bit 2 flags RI low-to-high trailing edge
// [R6] Bit 3 flags any DCD level change
// [R7] DSR, ring, DCD changes raise modem interrupt
// [R8] Bit 4 inverse CTS, loopback gives RTS
// [R9] Bit 5 inverse DSR, loopback gives DTR
// [R10] Bit 6 inverse RI, loopback gives user one
// [R11] Bit 7 inverse DCD, loopback gives user two
// [R12] Divide reference clock by 1 to 65535
// [R13] Divider output is sixteen times baud
// [R14] Divisor held as two byte latches
// [R15] Latch write reloads baud counter at once
// [R16] Software loads both latches before use
// [R17] Shift in characters into sixteen-byte buffer
// [R18] Receive timing from divisor, framing from line control
// [R19] Single-char mode: data interrupt until buffer read
// [R20] Buffer mode: interrupt from trigger setting
// [R21] Scratch byte stores data, affects nothing
// [R22] Modem control bit 5 enables autoflow
// [R23] Loopback takes change sources from modem control
// [R24] Handshake inputs synchronised before edge detection
// [R25] Change coinciding with read is kept
`timescale 1ns/1ns
`include "umsbr_regs.vh"

module umsbr_top #(
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire [5:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  input wire i_rx,
  input wire i_cts_n,
  input wire i_dsr_n,
  input wire i_ri_n,
  input wire i_dcd_n,
  output reg o_dtr_n,
  output reg o_rts_n,
  output reg o_user_output_one_n,
  output reg o_user_output_two_n,
  output reg o_rx_data_irq,
  output reg o_modem_status_irq
);

  // ****************************************************************
  // Receiver states
  // ****************************************************************
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_START = 3'd1;
  localparam [2:0] ST_DATA = 3'd2;
  localparam [2:0] ST_PARITY = 3'd3;
  localparam [2:0] ST_STOP = 3'd4;
  localparam [2:0] ST_WAIT_MARK = 3'd5;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg [7:0] int_enable; // Interrupt enables
  reg [7:0] fifo_control; // Buffer mode and trigger
  reg [7:0] line_control_register; // Framing settings
  reg [7:0] modem_control_register; // Handshake and loop controls
  reg [7:0] scratchpad; // Free byte for software
  reg [7:0] div_lo, div_hi; // Divisor low and high latches
  reg [3:0] delta, delta_shown; // Change bits, and those shown to a pending read
  reg [3:0] line_err, line_err_shown; // Overrun, parity, framing, break; shown copy
  reg [3:0] hs_meta, hs_sync; // Synchroniser stages one and two
  reg [3:0] level_prev; // Last seen status bits 7:4
  reg rx_meta, rx_sync; // Receive line synchroniser
  reg [15:0] baud_cnt; // Divider down counter
  reg tick16; // One pulse per 16x period
  reg [2:0] rx_state;
  reg [3:0] smp_cnt; // Ticks within a bit
  reg [2:0] bit_idx; // Data bit being shifted
  reg [7:0] receive_shift_register;
  reg par_acc, par_bit; // Running parity of data bits; received parity bit
  reg [AW-1:0] wr_ptr, rd_ptr; // Buffer pointers
  reg [AW:0] count; // Characters held
  reg [1:0] bus_phase; // 0 idle, 1 decoding, 2 answered
  reg [7:0] rd_byte; // Read mux output
  reg [3:0] levels, new_delta; // Current status bits 7:4; change events this cycle
  wire [4:0] trig_level; // Buffer trigger count
  wire [15:0] divisor = {div_hi, div_lo}; // [R14]
  wire [3:0] idx = i_avs_address[5:2];
  wire wr_acc = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
  wire rd_acc = i_avs_read & ~o_avs_waitrequest;
  wire [7:0] wdat = i_avs_writedata[7:0];
  wire loop_on = modem_control_register[`UMSBR_MODEMCTL_LOOP];
  wire autoflow_enable = modem_control_register[`UMSBR_MODEMCTL_AUTOFLOW]; // [R22]
  wire fifo_on = fifo_control[`UMSBR_FIFOCTL_EN];
  wire [2:0] nbits_m1 = {1'b1, line_control_register[1:0]};
  wire par_en = line_control_register[`UMSBR_LINECTL_PAREN];
  wire [10:0] head; // Head entry: errors and character
  wire push_stop = (rx_state == ST_STOP) & tick16 & (smp_cnt == `UMSBR_MID_BIT);
  wire is_full = fifo_on ? (count == DEPTH) : (count != 0);
  wire pop = rd_acc & (idx == `UMSBR_IDX_RXBUF) & (count != 0);
  wire push_ok = push_stop & ~is_full;
  wire clr_fifo = wr_acc & (idx == `UMSBR_IDX_FIFOCTL) & (wdat[1] | (wdat[0] != fifo_on));
  wire [7:0] aligned = receive_shift_register >> (3'd7 - nbits_m1);
  wire stop_low = ~rx_sync;
  wire perr = par_en & ((line_control_register[`UMSBR_LINECTL_STICK] ? par_bit :
              (par_acc ^ par_bit)) != ~line_control_register[`UMSBR_LINECTL_EVEN]);
  wire brk = stop_low & (aligned == 8'h00) & ~par_bit;

  // ****************************************************************
  // Receive buffer storage
  // ****************************************************************
  umsbr_rx_fifo #(.WIDTH(11), .DEPTH(DEPTH), .AW(AW)) u_store (
    .i_clk(i_clk),
    .i_wr_en(push_ok),
    .i_wr_addr(wr_ptr),
    .i_wr_data({brk, stop_low, perr, aligned}),
    .i_rd_addr(rd_ptr),
    .o_rd_data(head)
  );
  // ****************************************************************
  // Handshake status levels and change detection
  // ****************************************************************
  // Status bits 7:4: pins inverted, or looped from modem control
  always @* begin
    levels = ~hs_sync; // [R8] [R9] [R10] [R11]
    if (loop_on) levels = {modem_control_register[`UMSBR_MODEMCTL_USER2], // [R11] [R23]
                           modem_control_register[`UMSBR_MODEMCTL_USER1], // [R10]
                           modem_control_register[`UMSBR_MODEMCTL_DTR], // [R9]
                           modem_control_register[`UMSBR_MODEMCTL_RTS]}; // [R8]
    new_delta[0] = (levels[0] ^ level_prev[0]) & ~autoflow_enable; // [R2] [R3]
    new_delta[1] = levels[1] ^ level_prev[1]; // [R4]
    new_delta[2] = level_prev[2] & ~levels[2]; // [R5]
    new_delta[3] = levels[3] ^ level_prev[3]; // [R6]
  end
  // Two-flop synchronisers; only stage two is read downstream
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      hs_meta <= 4'hF;
      hs_sync <= 4'hF;
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      level_prev <= 4'h0;
    end else begin
      hs_meta <= {i_dcd_n, i_ri_n, i_dsr_n, i_cts_n}; // [R24]
      hs_sync <= hs_meta; // [R24]
      rx_meta <= loop_on ? 1'b1 : i_rx; // Receiver cut off in loopback
      rx_sync <= rx_meta;
      level_prev <= levels;
    end
  end
  // Sticky change bits; only bits handed to the reader are cleared,
  // so an event in the read window survives
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      delta <= 4'h0;
    end else begin
      delta <= new_delta | (delta & ~({4{rd_acc & (idx == `UMSBR_IDX_MODEMSTAT)}} & // [R1] [R25]
               delta_shown)); // [R2] [R4] [R5] [R6]
      if (autoflow_enable) delta[0] <= 1'b0; // [R3]
    end
  end
  // ****************************************************************
  // Baud generator
  // ****************************************************************
  // Down counter; a latch write reloads it so no long first count
  always @(posedge i_clk) begin
    tick16 <= 1'b0; // Pulses only where the count ends
    if (i_sys_rst) baud_cnt <= `UMSBR_RST_DIV;
    else if (wr_acc & (idx == `UMSBR_IDX_DIVLO)) baud_cnt <= {div_hi, wdat}; // [R15]
    else if (wr_acc & (idx == `UMSBR_IDX_DIVHI)) baud_cnt <= {wdat, div_lo}; // [R15]
    else if (divisor == 16'h0000) baud_cnt <= baud_cnt; // Illegal zero: generator stops
    else if (baud_cnt <= 16'h0001) begin
      baud_cnt <= divisor; // [R12]
      tick16 <= 1'b1; // [R13]
    end else begin
      baud_cnt <= baud_cnt - 16'h0001;
    end
  end
  // ****************************************************************
  // Receiver
  // ****************************************************************
  // Start bit checked at mid point to reject glitches, then one
  // sample per 16 ticks; a break loads one zero then waits for mark
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      rx_state <= ST_IDLE;
      smp_cnt <= 4'h0;
      bit_idx <= 3'd0;
      receive_shift_register <= `UMSBR_RST_BYTE;
      par_acc <= 1'b0;
      par_bit <= 1'b0;
    end else begin
      case (rx_state)
        ST_IDLE: if (~rx_sync) rx_state <= ST_START; // Sample counter is already zero here
        ST_START: begin
          if (tick16) begin
            smp_cnt <= smp_cnt + 4'h1;
            if (smp_cnt == `UMSBR_MID_START) begin
              smp_cnt <= 4'h0;
              bit_idx <= 3'd0;
              par_acc <= 1'b0;
              par_bit <= 1'b0;
              rx_state <= rx_sync ? ST_IDLE : ST_DATA; // False start back to idle
            end
          end
        end
        ST_DATA: begin
          if (tick16) begin
            smp_cnt <= smp_cnt + 4'h1;
            if (smp_cnt == `UMSBR_MID_BIT) begin
              receive_shift_register <= {rx_sync, receive_shift_register[7:1]}; // [R17]
              par_acc <= par_acc ^ rx_sync;
              bit_idx <= bit_idx + 3'd1;
              if (bit_idx == nbits_m1) rx_state <= par_en ? ST_PARITY : ST_STOP; // [R18]
            end
          end
        end
        ST_PARITY: begin
          if (tick16) begin
            smp_cnt <= smp_cnt + 4'h1;
            if (smp_cnt == `UMSBR_MID_BIT) begin
              par_bit <= rx_sync;
              rx_state <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (tick16) begin
            smp_cnt <= smp_cnt + 4'h1;
            if (smp_cnt == `UMSBR_MID_BIT) rx_state <= brk ? ST_WAIT_MARK : ST_IDLE;
          end
        end
        ST_WAIT_MARK: if (rx_sync) rx_state <= ST_IDLE;
        default: rx_state <= ST_IDLE;
      endcase
    end
  end
  // ****************************************************************
  // Receive buffer pointers and line errors
  // ****************************************************************
  // Single-character mode uses one slot; a character arriving while
  // it is occupied is dropped and flagged as overrun
  always @(posedge i_clk) begin
    if (i_sys_rst | clr_fifo) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push_ok) wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1}; // [R17]
      if (pop) rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      if (push_ok & ~pop) count <= count + {{AW{1'b0}}, 1'b1};
      else if (pop & ~push_ok) count <= count - {{AW{1'b0}}, 1'b1};
    end
  end
  // Error flags: overrun at push, others when their character
  // is popped from the head; a new error wins over the read clear
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      line_err <= 4'h0;
    end else begin
      line_err <= line_err & ~((rd_acc & (idx == `UMSBR_IDX_LINESTAT)) ? line_err_shown : 4'h0);
      if (push_stop & is_full) line_err[0] <= 1'b1; // Overrun: character dropped
      if (pop) line_err[3:1] <= line_err[3:1] | head[10:8]; // Head errors revealed
    end
  end
  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Software writes take effect on the edge that ends the answer cycle
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      int_enable <= `UMSBR_RST_BYTE;
      fifo_control <= `UMSBR_RST_BYTE;
      line_control_register <= `UMSBR_RST_LINECTL;
      modem_control_register <= `UMSBR_RST_BYTE;
      scratchpad <= `UMSBR_RST_BYTE;
      div_lo <= `UMSBR_RST_BYTE;
      div_hi <= `UMSBR_RST_BYTE;
    end else if (wr_acc) begin
      case (idx)
        `UMSBR_IDX_INTEN: int_enable <= wdat;
        `UMSBR_IDX_FIFOCTL: fifo_control <= {wdat[7:2], 1'b0, wdat[0]}; // Clear self-resets
        `UMSBR_IDX_LINECTL: line_control_register <= wdat; // [R18]
        `UMSBR_IDX_MODEMCTL: modem_control_register <= {2'b00, wdat[5:0]}; // [R22]
        `UMSBR_IDX_SCRATCH: scratchpad <= wdat; // [R21]
        `UMSBR_IDX_DIVLO: div_lo <= wdat; // [R14] [R16]
        `UMSBR_IDX_DIVHI: div_hi <= wdat; // [R14] [R16]
        default: ; // Unmapped or read-only: write ignored
      endcase
    end
  end
  // ****************************************************************
  // Bus slave
  // ****************************************************************
  // Read mux; the buffer head is shown with the data-ready state
  always @* begin
    case (idx)
      `UMSBR_IDX_RXBUF: rd_byte = head[7:0];
      `UMSBR_IDX_INTEN: rd_byte = int_enable;
      `UMSBR_IDX_FIFOCTL: rd_byte = fifo_control;
      `UMSBR_IDX_LINECTL: rd_byte = line_control_register;
      `UMSBR_IDX_MODEMCTL: rd_byte = modem_control_register;
      `UMSBR_IDX_LINESTAT: rd_byte = {3'b000, line_err[3], line_err[1], line_err[2],
                                      line_err[0], count != 0};
      `UMSBR_IDX_MODEMSTAT: rd_byte = {levels, delta}; // [R8] [R9] [R10] [R11]
      `UMSBR_IDX_SCRATCH: rd_byte = scratchpad; // [R21]
      `UMSBR_IDX_DIVLO: rd_byte = div_lo;
      `UMSBR_IDX_DIVHI: rd_byte = div_hi;
      default: rd_byte = 8'h00;
    endcase
  end
  // Two wait cycles, then one answer cycle; the gap lets the
  // registered buffer head settle after a pop
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      bus_phase <= 2'd0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= `UMSBR_BUS_ZERO;
      delta_shown <= 4'h0;
      line_err_shown <= 4'h0;
    end else begin
      case (bus_phase)
        2'd0: if (i_avs_read | i_avs_write) bus_phase <= 2'd1;
        2'd1: begin
          bus_phase <= 2'd2;
          o_avs_waitrequest <= 1'b0;
          o_avs_readdata <= {24'h00_0000, rd_byte};
          delta_shown <= (i_avs_read & (idx == `UMSBR_IDX_MODEMSTAT)) ? delta : 4'h0; // [R25]
          line_err_shown <= line_err;
        end
        default: begin
          bus_phase <= 2'd0;
          o_avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end
  // ****************************************************************
  // Pins and interrupts
  // ****************************************************************
  // Receive data level: trigger count in buffer mode, any character
  // otherwise; trigger codes map to 1, 4, 8 and 14 characters
  assign trig_level = (fifo_control[7:6] == 2'b00) ? 5'd1 : (fifo_control[7:6] == 2'b01) ? 5'd4 :
                      (fifo_control[7:6] == 2'b10) ? 5'd8 : 5'd14;
  // Registered outputs; handshakes inactive in loopback
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_dtr_n <= 1'b1;
      o_rts_n <= 1'b1;
      o_user_output_one_n <= 1'b1;
      o_user_output_two_n <= 1'b1;
      o_rx_data_irq <= 1'b0;
      o_modem_status_irq <= 1'b0;
    end else begin
      o_dtr_n <= loop_on | ~modem_control_register[`UMSBR_MODEMCTL_DTR];
      o_rts_n <= loop_on | ~modem_control_register[`UMSBR_MODEMCTL_RTS];
      o_user_output_one_n <= loop_on | ~modem_control_register[`UMSBR_MODEMCTL_USER1];
      o_user_output_two_n <= loop_on | ~modem_control_register[`UMSBR_MODEMCTL_USER2];
      o_rx_data_irq <= int_enable[`UMSBR_INTEN_RXDATA] & (fifo_on ? (count >= trig_level) : // [R20]
                       (count != 0)); // [R19]
      o_modem_status_irq <= int_enable[`UMSBR_INTEN_MODEM] &
                            ((delta[0] & ~autoflow_enable) | (|delta[3:1])); // [R3] [R7]
    end
  end
endmodule // umsbr_top

// ==== verification/umsbr_sva.sv ====
/* Checker: register answers, status bits, interrupt drops.
   Assumes binding to umsbr_top; pins move at clock edges. */
`timescale 1ns/1ns
module umsbr_sva (
  input wire i_clk,
  input wire i_sys_rst,
  input wire [5:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  input wire [31:0] o_avs_readdata,
  input wire o_avs_waitrequest,
  input wire i_cts_n,
  input wire i_dsr_n,
  input wire i_ri_n,
  input wire i_dcd_n,
  input wire o_rx_data_irq,
  input wire o_modem_status_irq
);
  // ********
  // Shadow state
  // ********
  reg [7:0] sh [0:15]; // Last byte written per index
  reg [3:0] last; // Pins one clock ago
  reg [3:0] quiet; // Clocks without a source change, saturating
  reg clean; // Change bits known to be zero
  integer k;
  wire [3:0] idx = i_avs_address[5:2]; // Register index
  wire ans = !o_avs_waitrequest; // Answer cycle
  wire rd_ms = ans && i_avs_read && idx == 4'h6; // Status read answered
  wire wr_ok = ans && i_avs_write && i_avs_byteenable[0]; // Write lands
  wire [3:0] pins = {i_dcd_n, i_ri_n, i_dsr_n, i_cts_n};
  wire chg = (pins != last) || (wr_ok && idx == 4'h4); // Source moved
  wire pop_cfg = ans && ((i_avs_read && idx == 4'h0) || (wr_ok && idx[3:1] == 3'h0));
  wire ms_cfg = rd_ms || (wr_ok && (idx == 4'h1 || idx == 4'h4));
  // Coarse on purpose: any pin change or modem control write restarts the settle wait
  always @(posedge i_clk) begin
    last <= pins;
    if (i_sys_rst) begin
      for (k = 0; k < 16; k = k + 1) begin
        sh[k] <= 8'h00;
      end
      quiet <= 4'h0;
      clean <= 1'b0;
    end else begin
      if (wr_ok) begin
        sh[idx] <= i_avs_writedata[7:0];
      end
      quiet <= chg ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
      clean <= !chg && (clean || (rd_ms && quiet > 4'h7));
    end
  end
  default clocking dc @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  scratch_keep_a: assert property (ans && i_avs_read && idx == 4'h7
    |-> o_avs_readdata[7:0] == sh[7]) else $error("scratch byte differs");
  divisor_latch_a: assert property (ans && i_avs_read && idx[3:1] == 3'h4
    |-> o_avs_readdata[7:0] == sh[idx]) else $error("divisor byte differs");
  pin_status_a: assert property (rd_ms && !sh[4][4] && quiet > 4'h7
    |-> o_avs_readdata[7:4] == ~pins) else $error("status levels differ");
  loop_status_a: assert property (rd_ms && sh[4][4] && quiet > 4'h7
    |-> o_avs_readdata[7:4] == {sh[4][3:2], sh[4][0], sh[4][1]})
    else $error("loop levels differ");
  autoflow_cts_a: assert property (rd_ms && sh[4][5]
    |-> !o_avs_readdata[0]) else $error("cts change under autoflow");
  change_clear_a: assert property (rd_ms && clean
    |-> o_avs_readdata[3:0] == 4'h0) else $error("change bits kept");
  rx_irq_drop_a: assert property ($fell(o_rx_data_irq)
    |-> $past(pop_cfg) || $past(pop_cfg, 2) || $past(pop_cfg, 3))
    else $error("data irq fell alone");
  ms_irq_drop_a: assert property ($fell(o_modem_status_irq)
    |-> $past(ms_cfg) || $past(ms_cfg, 2) || $past(ms_cfg, 3))
    else $error("modem irq fell alone");
  ms_irq_enable_a: assert property ($rose(o_modem_status_irq)
    |-> sh[1][3]) else $error("modem irq while masked");
  cover property (rd_ms && sh[4][4]);
  cover property ($rose(o_rx_data_irq));
  cover property ($rose(o_modem_status_irq));
endmodule // umsbr_sva
bind umsbr_top umsbr_sva chk (.*);

// ==== verification/umsbr_modem_model.sv ====
/* Modem-side model: handshake pins and serial frames.
   Assumes bit_clks is set to 16 times the divisor. */
`timescale 1ns/1ns
module umsbr_modem_model (
  input wire i_clk,
  output logic o_rx,
  output logic [3:0] o_hs_n
);
  int bit_clks = 32; // Clocks per serial bit
  // Lines idle inactive: rx at mark, handshakes high
  initial begin
    o_rx = 1'b1;
    o_hs_n = 4'hF;
  end
  // Pins move on an edge, then hold past the synchroniser
  task pins(input logic [3:0] v);
    begin
      @(posedge i_clk);
      o_hs_n <= v;
      repeat (8) @(posedge i_clk);
    end
  endtask
  // Start bit, eight data bits LSB first, one stop bit
  task send(input logic [7:0] b);
    logic [9:0] f;
    integer i;
    begin
      f = {1'b1, b, 1'b0};
      for (i = 0; i < 10; i = i + 1) begin
        @(posedge i_clk);
        o_rx <= f[i];
        repeat (bit_clks - 1) @(posedge i_clk);
      end
    end
  endtask
endmodule // umsbr_modem_model

// ==== verification/umsbr_top_tb.sv ====
/* Bench for umsbr_top: bus tasks, modem model, serial frames.
   Assumes a 10 MHz clock and the checker bound to the design. */
`timescale 1ns/1ns
module umsbr_top_tb;
  logic i_clk, i_sys_rst, i_avs_read, i_avs_write;
  logic [5:0] i_avs_address;
  logic [31:0] i_avs_writedata;
  logic [3:0] i_avs_byteenable;
  wire [31:0] o_avs_readdata;
  wire o_avs_waitrequest, rx, dtr_n, rts_n, u1_n, u2_n, rx_irq, ms_irq;
  wire [3:0] hs_n; // Handshake pins, dcd ri dsr cts
  logic [7:0] v; // Discarded read value
  integer errors, comparisons, i;
  umsbr_modem_model m (.i_clk(i_clk), .o_rx(rx), .o_hs_n(hs_n));
  umsbr_top dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_rx(rx), .i_cts_n(hs_n[0]),
    .i_dsr_n(hs_n[1]), .i_ri_n(hs_n[2]), .i_dcd_n(hs_n[3]), .o_dtr_n(dtr_n),
    .o_rts_n(rts_n), .o_user_output_one_n(u1_n), .o_user_output_two_n(u2_n),
    .o_rx_data_irq(rx_irq), .o_modem_status_irq(ms_irq));
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // Request holds until waitrequest is sampled low, then drops
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be,
    output logic [7:0] r);
    integer n;
    begin
      i_avs_address <= {a, 2'b00};
      i_avs_writedata <= {24'h00_0000, d};
      i_avs_byteenable <= be;
      i_avs_write <= w;
      i_avs_read <= !w;
      n = 0;
      @(posedge i_clk);
      while (o_avs_waitrequest !== 1'b0 && n < 40) begin
        @(posedge i_clk);
        n = n + 1;
      end
      if (n == 40) chk("waitrequest", 8'h00, 8'h01);
      r = o_avs_readdata[7:0];
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
      @(posedge i_clk);
    end
  endtask
  task rd(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] r;
    begin
      bus(1'b0, a, 8'h00, 4'hF, r);
      chk($sformatf("reg %h", a), exp, r);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF, v);
  endtask
  task irq(input logic [1:0] exp);
    begin
      repeat (2) @(posedge i_clk);
      chk("irqs", {6'h00, exp}, {6'h00, rx_irq, ms_irq});
    end
  endtask
  task wrap_up;
    begin
      $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  // Watchdog: runs need about a thousand clocks
  initial begin
    repeat (20000) @(posedge i_clk);
    errors = errors + 1;
    $display("[ERR] run expected done seen hung");
    wrap_up;
  end
  // ********
  // Tests
  // ********
  initial begin
    errors = 0;
    comparisons = 0;
    i_sys_rst = 1'b1;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_address = 6'h00;
    i_avs_writedata = 32'h0000_0000;
    i_avs_byteenable = 4'h0;
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    rd(4'h7, 8'h00);
    wr(4'h7, 8'hA5);
    bus(1'b1, 4'h7, 8'h3C, 4'h0, v);
    rd(4'h7, 8'hA5);
    rd(4'hF, 8'h00);
    wr(4'h8, 8'h02);
    wr(4'h9, 8'h00);
    rd(4'h8, 8'h02);
    $display("Test registers done");
    wr(4'h1, 8'h08);
    rd(4'h6, 8'h00);
    m.pins(4'hE);
    irq(2'h1);
    rd(4'h6, 8'h11);
    rd(4'h6, 8'h10);
    irq(2'h0);
    m.pins(4'h4);
    irq(2'h1);
    rd(4'h6, 8'hBA);
    m.pins(4'h0);
    irq(2'h0);
    rd(4'h6, 8'hF0);
    m.pins(4'h4);
    rd(4'h6, 8'hB4);
    wr(4'h4, 8'h20);
    m.pins(4'h5);
    irq(2'h0);
    rd(4'h6, 8'hA0);
    wr(4'h4, 8'h1F);
    irq(2'h1);
    bus(1'b0, 4'h6, 8'h00, 4'hF, v);
    chk("loop pins", 8'h0F, {4'h0, u2_n, u1_n, rts_n, dtr_n});
    rd(4'h6, 8'hF0);
    wr(4'h4, 8'h15);
    irq(2'h1);
    rd(4'h6, 8'h69);
    wr(4'h4, 8'h00);
    $display("Test modem status done");
    wr(4'h1, 8'h01);
    m.send(8'h5A);
    irq(2'h2);
    rd(4'h0, 8'h5A);
    irq(2'h0);
    wr(4'h8, 8'h01);
    m.bit_clks = 16;
    wr(4'h2, 8'h01);
    for (i = 0; i < 3; i = i + 1) begin
      m.send(8'hC3 ^ i[7:0]);
    end
    irq(2'h2);
    for (i = 0; i < 3; i = i + 1) begin
      rd(4'h0, 8'hC3 ^ i[7:0]);
    end
    irq(2'h0);
    $display("Test receive done");
    wrap_up;
  end
endmodule // umsbr_top_tb
